// ### design/axil_reg_port.sv
`timescale 1ns/100ps
`default_nettype none

`include "hbridge_defs.svh"

module axil_reg_port #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,                  // bus clock
  input wire logic reset_n,                  // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,            // write address valid
  output logic s_axi_awready,                // write address ready
  input wire logic [31:0] s_axi_wdata,       // write data
  input wire logic [3:0] s_axi_wstrb,        // byte enables
  input wire logic s_axi_wvalid,             // write data valid
  output logic s_axi_wready,                 // write data ready
  output logic [1:0] s_axi_bresp,            // write response
  output logic s_axi_bvalid,                 // write response valid
  input wire logic s_axi_bready,             // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,            // read address valid
  output logic s_axi_arready,                // read address ready
  output logic [31:0] s_axi_rdata,           // read data
  output logic [1:0] s_axi_rresp,            // read response
  output logic s_axi_rvalid,                 // read data valid
  input wire logic s_axi_rready,             // read data ready
  output logic wrStrobe,                     // one-cycle register write
  output logic [ADDR_W-1:0] wrAddr,          // write byte address
  output logic [31:0] wrData,                // write data
  output logic [3:0] wrStrb,                 // write byte enables
  input wire logic wrOk,                     // address mapped
  output logic rdStrobe,                     // one-cycle register read
  output logic [ADDR_W-1:0] rdAddr,          // read byte address
  input wire logic [31:0] rdData,            // read value
  input wire logic rdOk                      // address mapped
);

  logic awHeld_q, wHeld_q, rdPend_q;
  logic awHeld_d, wHeld_d, bValid_d, rValid_d, rdPend_d;
  logic awTake, wTake, arTake;

  // ************************************************
  // write channel
  // ************************************************
  // address and data are caught in either order; readies drop while a response waits
  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  assign wrStrobe = awHeld_q && wHeld_q;
  assign awHeld_d = (awHeld_q || awTake) && !wrStrobe;
  assign wHeld_d = (wHeld_q || wTake) && !wrStrobe;
  assign bValid_d = wrStrobe || (s_axi_bvalid && !s_axi_bready);

  // write state
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      s_axi_bvalid <= bValid_d;
      if (wrStrobe)
        s_axi_bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      s_axi_awready <= !awHeld_d && !bValid_d;
      s_axi_wready <= !wHeld_d && !bValid_d;
    end
  end

  // write payload, no reset needed
  always_ff @(posedge ref_clk)
  begin
    if (awTake)
      wrAddr <= s_axi_awaddr;
    if (wTake)
    begin
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end
  end

  // ************************************************
  // read channel
  // ************************************************
  // one read in flight; data is sampled the cycle after the address
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign rdStrobe = rdPend_q;
  assign rdPend_d = arTake;
  assign rValid_d = rdPend_q || (s_axi_rvalid && !s_axi_rready);

  // read state
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rdPend_q <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      rdPend_q <= rdPend_d;
      s_axi_rvalid <= rValid_d;
      s_axi_arready <= !rdPend_d && !rValid_d;
      if (rdPend_q)
      begin
        s_axi_rdata <= rdOk ? rdData : 32'h0;
        s_axi_rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // read address capture
  always_ff @(posedge ref_clk)
  begin
    if (arTake)
      rdAddr <= s_axi_araddr;
  end

endmodule

`default_nettype wire

// ### design/bridge_switch_map.sv
`timescale 1ns/100ps
`default_nettype none

module bridge_switch_map (
  input wire logic enabled,                 // channel not in off mode
  input wire hbridge_pkg::out_mode_t mode,  // output mode field
  input wire logic active,                  // pwm active phase
  input wire logic decay,                   // recirculation path select
  input wire logic sign,                    // sign of working duty
  output hbridge_pkg::bridge_ctl_t ctl      // switch drive and state
);

  // ************************************************
  // transistor table
  // ************************************************
  // off mode leaves every switch undriven (see R10)
  always_comb
  begin
    ctl = '0;
    if (enabled)
    begin
      unique case (mode)
        hbridge_pkg::HALF_LOW:
        begin
          ctl.driven = 4'hC;
          ctl.on = active ? 4'h8 : 4'h4;  // see R11
        end
        hbridge_pkg::HALF_HIGH:
        begin
          ctl.driven = 4'h3;
          ctl.on = active ? 4'h2 : 4'h1;  // see R11
        end
        hbridge_pkg::FULL_SINGLE, hbridge_pkg::FULL_DUAL:
        begin
          ctl.driven = 4'hF;
          // sign picks the driven side only here, never in half modes (see R09)
          if (active)
            ctl.on = sign ? 4'h6 : 4'h9;  // see R12
          else
            ctl.on = decay ? 4'hA : 4'h5;  // see R13
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### design/hbridge_defs.svh
`ifndef HBRIDGE_DEFS_SVH
`define HBRIDGE_DEFS_SVH

// register indices; byte address is four times the index
`define CTRL_IDX 8'h00
`define PERIOD_IDX 8'h01
`define CHCFG_BASE_IDX 8'h10
`define DUTY_BASE_IDX 8'h20

// field positions
`define FAST_BIT 0
`define CHCFG_W 5
`define ALIGN_LSB 0
`define MODE_LSB 2
`define DECAY_BIT 4
`define SIGN_BIT 15

// reset values
`define DUTY_RESET 16'h0000
`define PERIOD_RESET 16'h0000
`define CHCFG_RESET 5'h00

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### design/hbridge_duty_buffer.sv
//
// Contract
// R01 - a duty write in byte format clears duty bits ten, nine, one and zero.
// R02 - in byte format a high-byte write alone sets sign and duty completely.
// R03 - the byte-format select alters only write and read views, never held duty values.
// R04 - writing the period value to zero copies every duty register into its working copy.
// R05 - a channel whose align field is zero copies its duty register into its working copy.
// R06 - in half or single full bridge mode each counter overflow loads the working duty.
// R07 - in dual full mode a pair loads only at an overflow after its odd register was written.
// R08 - reading a duty register returns the last written value, not the working one.
// R09 - the sign picks the driven bridge side in full modes and is ignored in half modes.
// R10 - in off mode all four switches are left undriven.
// R11 - half mode 00 drives switches three and four, mode 01 switches one and two.
// R12 - full mode active phase turns on one and four for sign 0, two and three for sign 1.
// R13 - full mode passive phase turns on one and three for decay 0, two and four for 1.
// R14 - in byte format the low byte reads zero, and every duty register resets to zero.
//
`timescale 1ns/100ps
`default_nettype none
`include "hbridge_defs.svh"

module hbridge_duty_buffer #(
  parameter int NUM_CH = 12,
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,                   // 50 MHz bus clock
  input wire logic reset_n,                   // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
  input wire logic s_axi_awvalid,             // write address valid
  output logic s_axi_awready,                 // write address ready
  input wire logic [31:0] s_axi_wdata,        // write data
  input wire logic [3:0] s_axi_wstrb,         // byte enables
  input wire logic s_axi_wvalid,              // write data valid
  output logic s_axi_wready,                  // write data ready
  output logic [1:0] s_axi_bresp,             // write response
  output logic s_axi_bvalid,                  // write response valid
  input wire logic s_axi_bready,              // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
  input wire logic s_axi_arvalid,             // read address valid
  output logic s_axi_arready,                 // read address ready
  output logic [31:0] s_axi_rdata,            // read data
  output logic [1:0] s_axi_rresp,             // read response
  output logic s_axi_rvalid,                  // read data valid
  input wire logic s_axi_rready,              // read data ready
  input wire logic timerOverflow,             // pwm counter overflow pulse
  input wire logic [NUM_CH-1:0] pwmActive,    // per-channel active phase
  output hbridge_pkg::bridge_ctl_t [NUM_CH-1:0] bridgeCtl  // registered switch control
);

  localparam int NUM_PAIR = NUM_CH / 2;

  logic wrStrobe, wrOk, rdOk;
  logic [ADDR_W-1:0] wrAddr, rdAddr;
  logic [31:0] wrData, rdData;
  logic [3:0] wrStrb;
  logic [7:0] wIdx, rIdx;
  logic fast_q;
  logic [15:0] period_q, periodD;
  logic perZeroWr;
  hbridge_pkg::ch_cfg_t [NUM_CH-1:0] cfg_q;
  logic [NUM_CH-1:0][15:0] shadow_q;
  logic [NUM_CH-1:0][15:0] work_q;
  logic [NUM_PAIR-1:0] pend_q;
  logic [NUM_CH-1:0] wrDuty, wrCfg, copyNow;
  hbridge_pkg::bridge_ctl_t [NUM_CH-1:0] ctlD;

  // ************************************************
  // bus slave
  // ************************************************
  axil_reg_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdStrobe(),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // word index; address bits above bit nine are dropped, so higher addresses alias lower ones
  assign wIdx = wrAddr[9:2];
  assign rIdx = rdAddr[9:2];

  // ************************************************
  // duty formats
  // ************************************************
  // byte format keeps the canonical layout inside, so toggling it moves nothing
  function automatic logic [15:0] dutyMerge(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be, input logic fast);
    logic [15:0] r;
    r = old;
    if (fast)
    begin
      if (be[1])
        r = {wd[15], 6'h00, wd[14:8], 2'h0};  // see R01, R02
    end
    else
    begin
      if (be[0])
        r[7:0] = wd[7:0];
      if (be[1])
        r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // read view; low byte is unimplemented in byte format
  function automatic logic [15:0] dutyView(input logic [15:0] v, input logic fast);
    return fast ? {v[15], v[8:2], 8'h00} : v;  // see R14
  endfunction

  // ************************************************
  // global registers
  // ************************************************
  // period write of zero forces a reload of every channel
  always_comb
  begin
    periodD = period_q;
    if (wrStrb[0])
      periodD[7:0] = wrData[7:0];
    if (wrStrb[1])
      periodD[15:8] = wrData[15:8];
  end

  assign perZeroWr = wrStrobe && wIdx == `PERIOD_IDX && periodD == 16'h0000;  // see R04

  // byte-format select; only the write and read paths look at it (see R03)
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      fast_q <= 1'b0;
    else if (wrStrobe && wIdx == `CTRL_IDX && wrStrb[0])
      fast_q <= wrData[`FAST_BIT];
  end

  // period value register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      period_q <= `PERIOD_RESET;
    else if (wrStrobe && wIdx == `PERIOD_IDX)
      period_q <= periodD;
  end

  // ************************************************
  // per-channel logic
  // ************************************************
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    assign wrDuty[c] = wrStrobe && wIdx == 8'(`DUTY_BASE_IDX + c);
    assign wrCfg[c] = wrStrobe && wIdx == 8'(`CHCFG_BASE_IDX + c);
    // dual mode waits for the pair's odd register; other modes load each overflow
    assign copyNow[c] = perZeroWr  // see R04
      || cfg_q[c].align == 2'h0  // see R05
      || (timerOverflow && cfg_q[c].mode != hbridge_pkg::FULL_DUAL)  // see R06
      || (timerOverflow && pend_q[c/2]);  // see R07

    // bus-visible duty, holds the last written value (see R08)
    always_ff @(posedge ref_clk)
    begin
      if (!reset_n)
        shadow_q[c] <= `DUTY_RESET;  // see R14
      else if (wrDuty[c])
        shadow_q[c] <= dutyMerge(shadow_q[c], wrData[15:0], wrStrb[1:0], fast_q);
    end

    // channel configuration
    always_ff @(posedge ref_clk)
    begin
      if (!reset_n)
        cfg_q[c] <= hbridge_pkg::ch_cfg_t'(`CHCFG_RESET);
      else if (wrCfg[c] && wrStrb[0])
        cfg_q[c] <= hbridge_pkg::ch_cfg_t'(wrData[`CHCFG_W-1:0]);
    end

    // working duty; a copy takes the shadow as it stood before any same-edge write
    always_ff @(posedge ref_clk)
    begin
      if (!reset_n)
        work_q[c] <= `DUTY_RESET;
      else if (copyNow[c])
        work_q[c] <= shadow_q[c];
    end

    bridge_switch_map u_map (
      .enabled(cfg_q[c].align != 2'h0),  // see R10
      .mode(cfg_q[c].mode),
      .active(pwmActive[c]),
      .decay(cfg_q[c].decay),
      .sign(work_q[c][`SIGN_BIT]),  // see R09
      .ctl(ctlD[c])
    );

    // switch outputs leave from flip-flops to avoid glitches on the gates
    always_ff @(posedge ref_clk)
    begin
      if (!reset_n)
        bridgeCtl[c] <= '0;
      else
        bridgeCtl[c] <= ctlD[c];
    end
  end

  // ************************************************
  // dual full pair arming
  // ************************************************
  // a write on the same edge as an overflow keeps the pair armed
  for (genvar p = 0; p < NUM_PAIR; p++)
  begin : g_pair
    always_ff @(posedge ref_clk)
    begin
      if (!reset_n)
        pend_q[p] <= 1'b0;
      else if (wrDuty[2*p+1])
        pend_q[p] <= 1'b1;  // see R07
      else if (timerOverflow)
        pend_q[p] <= 1'b0;
    end
  end

  // ************************************************
  // decode answers
  // ************************************************
  assign wrOk = wIdx == `CTRL_IDX || wIdx == `PERIOD_IDX || (|wrDuty) || (|wrCfg);

  // read multiplexer
  always_comb
  begin
    rdData = 32'h0;
    rdOk = 1'b0;
    if (rIdx == `CTRL_IDX)
    begin
      rdData[`FAST_BIT] = fast_q;
      rdOk = 1'b1;
    end
    if (rIdx == `PERIOD_IDX)
    begin
      rdData[15:0] = period_q;
      rdOk = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rIdx == 8'(`CHCFG_BASE_IDX + i))
      begin
        rdData[`CHCFG_W-1:0] = cfg_q[i];
        rdOk = 1'b1;
      end
      if (rIdx == 8'(`DUTY_BASE_IDX + i))
      begin
        rdData[15:0] = dutyView(shadow_q[i], fast_q);  // see R08
        rdOk = 1'b1;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence dualArmed;
    cfg_q[1].mode == hbridge_pkg::FULL_DUAL && cfg_q[1].align != 2'h0 && pend_q[0];
  endsequence

  sequence fireOnOverflow;
    dualArmed ##0 timerOverflow;
  endsequence

  fast_mask_a: assert property (wrDuty[2] && fast_q && wrStrb[1] |=>  // see R01
    shadow_q[2][10:9] == 2'h0 && shadow_q[2][1:0] == 2'h0) else $error("low duty bits set");
  hi_byte_a: assert property (wrDuty[2] && fast_q && wrStrb[1] |=> shadow_q[2] ==  // see R02
    {$past(wrData[15]), 6'h00, $past(wrData[14:8]), 2'h0}) else $error("high byte lost");
  fast_keep_a: assert property (!wrDuty[0] && !copyNow[0] |=>  // see R03
    $stable(shadow_q[0]) && $stable(work_q[0])) else $error("duty moved without a write");
  zero_reload_a: assert property (perZeroWr |=> work_q[2] == $past(shadow_q[2]))  // see R04
    else $error("period zero did not reload");
  align_copy_a: assert property (cfg_q[0].align == 2'h0 |=>  // see R05
    work_q[0] == $past(shadow_q[0])) else $error("disabled channel not reloaded");
  ovf_copy_a: assert property (timerOverflow &&  // see R06
    cfg_q[0].mode != hbridge_pkg::FULL_DUAL |=> work_q[0] == $past(shadow_q[0]))
    else $error("overflow reload missing");
  dual_fire_a: assert property (fireOnOverflow |=>  // see R07
    work_q[1] == $past(shadow_q[1])) else $error("armed pair did not load");
  dual_hold_a: assert property (cfg_q[1].mode == hbridge_pkg::FULL_DUAL &&  // see R07
    cfg_q[1].align != 2'h0 && !pend_q[0] && !perZeroWr |=> $stable(work_q[1]))
    else $error("unarmed pair loaded");
  read_back_a: assert property (wrDuty[0] && !fast_q && wrStrb[1:0] == 2'h3  // see R08
    ##1 !wrDuty[0] |-> shadow_q[0] == $past(wrData[15:0])) else $error("readback differs");
  off_free_a: assert property (cfg_q[0].align == 2'h0 |=>  // see R10
    bridgeCtl[0].driven == 4'h0) else $error("off channel drives switches");
  full_drive_a: assert property (cfg_q[0].align != 2'h0 &&  // see R12
    cfg_q[0].mode == hbridge_pkg::FULL_SINGLE && pwmActive[0] |=> bridgeCtl[0].on ==
    ($past(work_q[0][`SIGN_BIT]) ? 4'h6 : 4'h9)) else $error("full active map wrong");

endmodule

`default_nettype wire

// ### design/hbridge_pkg.sv
package hbridge_pkg;

  // output mode field encodings, in field order 00..11
  typedef enum logic [1:0] {HALF_LOW, HALF_HIGH, FULL_SINGLE, FULL_DUAL} out_mode_t;

  // per-channel configuration word, low bits of its register
  typedef struct packed {
    logic decay;
    out_mode_t mode;
    logic [1:0] align;
  } ch_cfg_t;

  // bit 0 is switch one ... bit 3 is switch four
  typedef struct packed {
    logic [3:0] driven;
    logic [3:0] on;
  } bridge_ctl_t;

endpackage

// ### tb/bridge_load_model.sv
`timescale 1ns/100ps
`default_nettype none

// ******************
// external bridge
// ******************
// switches one and two form one leg, three and four the other;
// an undriven switch is taken as open, so only driven-and-on conducts
module bridge_load_model (
  input wire hbridge_pkg::bridge_ctl_t ctl,  // switch control from the block
  output logic shootThrough                  // a leg shorts supply to ground
);
  logic [3:0] closed;

  // both switches of one leg closed would burn the real transistors
  assign closed = ctl.driven & ctl.on;
  assign shootThrough = (closed[0] & closed[1]) | (closed[2] & closed[3]);
endmodule

`default_nettype wire

// ### tb/hbridge_duty_buffer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end

module hbridge_duty_buffer_tb_top;
  logic ref_clk, reset_n, timerOverflow, shootThrough;
  logic [11:0] s_axi_awaddr, s_axi_araddr, pwmActive;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] rd;
  hbridge_pkg::bridge_ctl_t [11:0] bridgeCtl;
  int n_fail, n_compared;

  hbridge_duty_buffer #(.NUM_CH(12), .ADDR_W(12)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timerOverflow(timerOverflow),
    .pwmActive(pwmActive), .bridgeCtl(bridgeCtl)
  );

  bridge_load_model load0 (.ctl(bridgeCtl[0]), .shootThrough(shootThrough));

  // ***********
  // bus tasks
  // ***********
  // each channel is released only at the edge where its ready was seen
  task automatic axiWrite(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= be;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] idx);
    @(posedge ref_clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata[15:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // outputs trail their causes by a copy edge and a map edge, so let three pass
  task automatic chkCtl(input logic [7:0] exp);
    repeat (3) @(posedge ref_clk);
    `CHK("bridgeCtl", exp, bridgeCtl[0])
    `CHK("shootThrough", 1'b0, shootThrough)
  endtask

  task automatic overflow();
    @(posedge ref_clk);
    timerOverflow <= 1'b1;
    @(posedge ref_clk);
    timerOverflow <= 1'b0;
  endtask

  // expected switch pattern {driven, on}, bit 0 is switch one
  function automatic logic [7:0] expMap(input int m, input logic dc, input logic act,
                                        input logic sg);
    case (m)
      0: expMap = act ? 8'hC8 : 8'hC4;
      1: expMap = act ? 8'h32 : 8'h31;
      default: expMap = act ? (sg ? 8'hF6 : 8'hF9) : (dc ? 8'hFA : 8'hF5);
    endcase
  endfunction

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ***********
  // clock and watchdog
  // ***********
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // the whole sequence needs about 400 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end

  // ***********
  // tests
  // ***********
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    reset_n = 1'b0;
    timerOverflow = 1'b0;
    pwmActive = 12'h000;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    axiRead(8'h20);
    `CHK("dutyReset", 16'h0000, rd)
    chkCtl(8'h00);
    axiRead(8'hFF);
    `CHK("unmappedResp", 2'h2, resp)
    `CHK("unmappedData", 16'h0000, rd)
    axiWrite(8'hFF, 16'h1234, 4'h3);
    `CHK("unmappedWrResp", 2'h2, resp)
    $display("test reset done");
    // every mode, decay and phase, first with positive then negative working duty
    for (int s = 0; s < 2; s++)
    begin
      for (int m = 0; m < 4; m++)
        for (int k = 0; k < 4; k++)
        begin
          axiWrite(8'h10, {11'h000, k[1], m[1:0], 2'h1}, 4'h1);
          pwmActive <= {11'h000, k[0]};
          chkCtl(expMap(m, k[1], k[0], s[0]));
        end
      axiWrite(8'h10, 16'h0009, 4'h1);
      axiWrite(8'h20, 16'h8000, 4'h3);
      overflow();
    end
    $display("test map done");
    // shadow against working copy in single full mode, active phase
    pwmActive <= 12'h001;
    axiWrite(8'h20, 16'h0000, 4'h3);
    `CHK("dutyWrResp", 2'h0, resp)
    axiRead(8'h20);
    `CHK("dutyReadback", 16'h0000, rd)
    `CHK("dutyRdResp", 2'h0, resp)
    chkCtl(8'hF6);
    overflow();
    chkCtl(8'hF9);
    axiWrite(8'h20, 16'h8000, 4'h3);
    chkCtl(8'hF9);
    axiWrite(8'h01, 16'h0000, 4'h3);
    chkCtl(8'hF6);
    axiWrite(8'h20, 16'h0000, 4'h3);
    axiWrite(8'h10, 16'h0008, 4'h1);
    chkCtl(8'h00);
    axiWrite(8'h10, 16'h0009, 4'h1);
    chkCtl(8'hF9);
    $display("test copy done");
    // dual full pair loads only after its odd register was written
    axiWrite(8'h10, 16'h000D, 4'h1);
    axiWrite(8'h11, 16'h000D, 4'h1);
    axiWrite(8'h20, 16'h8000, 4'h3);
    overflow();
    chkCtl(8'hF9);
    axiWrite(8'h21, 16'h0000, 4'h3);
    overflow();
    chkCtl(8'hF6);
    `CHK("pairOddCtl", 8'hF5, bridgeCtl[1])
    $display("test pair done");
    // byte format writes and reads
    axiWrite(8'h00, 16'h0001, 4'h1);
    axiWrite(8'h22, 16'h00FF, 4'h1);
    axiRead(8'h22);
    `CHK("fastLowOnly", 16'h0000, rd)
    axiWrite(8'h22, 16'hFF00, 4'h2);
    axiRead(8'h22);
    `CHK("fastRead", 16'hFF00, rd)
    axiWrite(8'h00, 16'h0000, 4'h1);
    axiRead(8'h22);
    `CHK("fastStored", 16'h81FC, rd)
    axiWrite(8'h22, 16'hFFFF, 4'h3);
    axiWrite(8'h00, 16'h0001, 4'h1);
    axiWrite(8'h00, 16'h0000, 4'h1);
    axiRead(8'h22);
    `CHK("fastToggle", 16'hFFFF, rd)
    $display("test byte format done");
    stop_test();
  end
endmodule

`default_nettype wire
